// ===== design/udo_burst.sv
// Operation
// - Device opens burst by asserting request.
// - Drive ready negated after tZIORDY, hold.
// - Assert ready after STOP drops; hold.
// - No pause or termination before first word.
// - Device pauses by negating ready.
// - Accept late words after pause while the skid has room.
// - On STOP drop request and ready.
// - Device terminates: ready off, tRP, request off.
// - Closing strobe rise carries no word.
// - Latch, compare CRC; release ready.
// - CRC seeded 4ABA, bit 0 first.
// - Miscompare sets CRC and abort bits.
// - Terminate when done; discard surplus words.
// - Later clean burst keeps saved error.
module udo_burst (
  // System clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  // Link
  input  wire logic        LINK_CLK_I,
  input  wire logic        DMACK_N_I,
  input  wire logic        STOP_I,
  input  wire logic        HSTROBE_I,
  input  wire logic [15:0] DD_I,
  output logic             DMARQ_O,
  output logic             DDMARDY_N_O,
  output logic             DDMARDY_OE_O,
  // Command side
  input  wire logic        CMD_START_I,
  input  wire logic [15:0] CMD_WORDS_I,
  input  wire logic        CMD_END_I,
  input  wire logic        PAUSE_I,
  output logic      [15:0] WORD_O,
  output logic             WORD_VALID_O,
  output logic             BUSY_O,
  output logic      [7:0]  ERR_REG_O
);

  // ---------------- Link domain ----------------
  logic        dmack_s1, dmack_s2, stop_s1, stop_s2, hs_s1, hs_s2, hs_s3;
  logic [15:0] dd_s1, dd_s2;
  logic        start_s1, start_s2, start_s3, ack_s1, ack_s2, pause_s1, pause_s2;

  udo_pkg::udo_state_e state, next_state;
  logic [7:0]  tmr, next_tmr;
  logic [15:0] remaining, next_remaining;
  logic        first_word, next_first_word;
  logic [15:0] crc, next_crc, crc_fold;
  logic        crc_bad, next_crc_bad;
  logic        done_t, next_done_t;
  logic        busy_l, next_busy_l;
  logic        dmarq, next_dmarq, rdy_n, next_rdy_n, rdy_oe, next_rdy_oe;
  logic [15:0] skid [0:udo_pkg::SKID_DEPTH-1];
  logic [15:0] next_skid [0:udo_pkg::SKID_DEPTH-1];
  logic [2:0]  skid_cnt, next_skid_cnt;
  logic [15:0] hold, next_hold;
  logic        req_t, next_req_t;

  // System-domain state read by the link through crossings.
  logic        start_t;
  logic [15:0] words_hold;
  logic        req_s1, req_s2, req_s3;

  logic strobe_edge, inflight, want_pause, take_word;

  // Sampling of the link pins; every pin passes two flip-flops first.
  always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      dmack_s1 <= 1'b1;
      dmack_s2 <= 1'b1;
      stop_s1  <= 1'b0;
      stop_s2  <= 1'b0;
      hs_s1    <= 1'b1;
      hs_s2    <= 1'b1;
      hs_s3    <= 1'b1;
      dd_s1    <= 16'h0000;
      dd_s2    <= 16'h0000;
      start_s1 <= 1'b0;
      start_s2 <= 1'b0;
      start_s3 <= 1'b0;
      ack_s1   <= 1'b0;
      ack_s2   <= 1'b0;
      pause_s1 <= 1'b0;
      pause_s2 <= 1'b0;
    end else begin
      dmack_s1 <= DMACK_N_I;
      dmack_s2 <= dmack_s1;
      stop_s1  <= STOP_I;
      stop_s2  <= stop_s1;
      hs_s1    <= HSTROBE_I;
      hs_s2    <= hs_s1;
      hs_s3    <= hs_s2;
      dd_s1    <= DD_I;
      dd_s2    <= dd_s1;
      start_s1 <= start_t;
      start_s2 <= start_s1;
      start_s3 <= start_s2;
      ack_s1   <= req_s3;
      ack_s2   <= ack_s1;
      pause_s1 <= PAUSE_I;
      pause_s2 <= pause_s1;
    end
  end

  udo_crc16 u_crc (
    .crc_i  (crc),
    .word_i (dd_s2),
    .crc_o  (crc_fold)
  );

  assign strobe_edge = hs_s2 ^ hs_s3;
  assign inflight    = req_t ^ ack_s2;
  // Pausing as soon as one word waits keeps the late words inside the skid.
  assign want_pause  = pause_s2 || (skid_cnt != 3'h0);
  // Words taken on both strobe edges
  assign take_word   = strobe_edge && (state == udo_pkg::ST_XFER || state == udo_pkg::ST_PAUSE ||
                                       state == udo_pkg::ST_WAIT_RP);

  always_comb begin
    logic [2:0] cnt_after_pop;
    cnt_after_pop   = skid_cnt;
    next_state      = state;
    next_tmr        = tmr;
    next_remaining  = remaining;
    next_first_word = first_word;
    next_crc        = crc;
    next_crc_bad    = crc_bad;
    next_done_t     = done_t;
    next_dmarq      = dmarq;
    next_rdy_n      = rdy_n;
    next_rdy_oe     = rdy_oe;
    next_skid       = skid;
    next_hold       = hold;
    next_req_t      = req_t;

    // Handing words to the command side, one handshake at a time.
    if (!inflight && skid_cnt != 3'h0) begin
      next_hold  = skid[0];
      next_req_t = ~req_t;
      for (int i = 0; i < udo_pkg::SKID_DEPTH - 1; i++) begin
        next_skid[i] = skid[i+1];
      end
      cnt_after_pop = skid_cnt - 3'h1;
    end
    next_skid_cnt = cnt_after_pop;

    // Late words after a pause still land
    if (take_word) begin
      // Fold every data word into the CRC
      next_crc        = crc_fold;
      next_first_word = 1'b1;
      if (remaining != 16'h0000 && cnt_after_pop != udo_pkg::SKID_FULL) begin
        next_skid[cnt_after_pop[1:0]] = dd_s2;
        next_skid_cnt                 = cnt_after_pop + 3'h1;
        next_remaining                = remaining - 16'h0001;
      end
    end

    if (start_s2 ^ start_s3) begin
      next_remaining = words_hold;
    end

    unique case (state)
      udo_pkg::ST_IDLE: begin
        if (remaining != 16'h0000 && !pause_s2) begin
          next_dmarq      = 1'b1;
          next_crc        = udo_pkg::CRC_SEED;
          next_first_word = 1'b0;
          next_state      = udo_pkg::ST_REQ;
        end
      end
      udo_pkg::ST_REQ: begin
        if (!dmack_s2) begin
          next_tmr   = udo_pkg::ZIORDY_CYC;
          next_state = udo_pkg::ST_INIT;
        end
      end
      udo_pkg::ST_INIT: begin
        if (tmr != 8'h00) begin
          next_tmr = tmr - 8'h01;
        end else if (!rdy_oe) begin
          next_rdy_oe = 1'b1;
          next_rdy_n  = 1'b1;
        end else if (!stop_s2) begin
          next_rdy_n = 1'b0;
          next_state = udo_pkg::ST_XFER;
        end
      end
      udo_pkg::ST_XFER, udo_pkg::ST_PAUSE: begin
        if (stop_s2) begin
          next_dmarq = 1'b0;
          next_rdy_n = 1'b1;
          next_state = udo_pkg::ST_TERM;
        end else if (next_first_word && next_remaining == 16'h0000) begin
          next_rdy_n = 1'b1;
          next_tmr   = udo_pkg::RP_CYC;
          next_state = udo_pkg::ST_WAIT_RP;
        end else if (state == udo_pkg::ST_XFER && next_first_word && want_pause) begin
          next_rdy_n = 1'b1;
          next_state = udo_pkg::ST_PAUSE;
        end else if (state == udo_pkg::ST_PAUSE && !want_pause) begin
          next_rdy_n = 1'b0;
          next_state = udo_pkg::ST_XFER;
        end
      end
      udo_pkg::ST_WAIT_RP: begin
        if (stop_s2) begin
          next_dmarq = 1'b0;
          next_state = udo_pkg::ST_TERM;
        end else if (tmr == 8'h00) begin
          next_dmarq = 1'b0;
          next_state = udo_pkg::ST_TERM;
        end else begin
          next_tmr = tmr - 8'h01;
        end
      end
      udo_pkg::ST_TERM: begin
        if (dmack_s2) begin
          next_crc_bad = (dd_s2 != crc);
          next_done_t  = ~done_t;
          next_rdy_oe  = 1'b0;
          next_rdy_n   = 1'b1;
          next_state   = udo_pkg::ST_IDLE;
        end
      end
      default: begin
        next_dmarq  = 1'b0;
        next_rdy_oe = 1'b0;
        next_rdy_n  = 1'b1;
        next_state  = udo_pkg::ST_IDLE;
      end
    endcase

    next_busy_l = (next_state != udo_pkg::ST_IDLE) || (next_remaining != 16'h0000) || (next_skid_cnt != 3'h0);
  end

  always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state      <= udo_pkg::ST_IDLE;
      tmr        <= 8'h00;
      remaining  <= udo_pkg::WORDS_RESET;
      first_word <= 1'b0;
      crc        <= udo_pkg::CRC_SEED;
      crc_bad    <= 1'b0;
      done_t     <= 1'b0;
      busy_l     <= 1'b0;
      dmarq      <= 1'b0;
      rdy_n      <= 1'b1;
      rdy_oe     <= 1'b0;
      skid       <= '{default: 16'h0000};
      skid_cnt   <= 3'h0;
      hold       <= 16'h0000;
      req_t      <= 1'b0;
    end else begin
      state      <= next_state;
      tmr        <= next_tmr;
      remaining  <= next_remaining;
      first_word <= next_first_word;
      crc        <= next_crc;
      crc_bad    <= next_crc_bad;
      done_t     <= next_done_t;
      busy_l     <= next_busy_l;
      dmarq      <= next_dmarq;
      rdy_n      <= next_rdy_n;
      rdy_oe     <= next_rdy_oe;
      skid       <= next_skid;
      skid_cnt   <= next_skid_cnt;
      hold       <= next_hold;
      req_t      <= next_req_t;
    end
  end

  assign DMARQ_O      = dmarq;
  assign DDMARDY_N_O  = rdy_n;
  assign DDMARDY_OE_O = rdy_oe;

  // ---------------- System domain ----------------
  logic        done_s1, done_s2, done_s3, busy_s1, busy_s2;
  logic        next_start_t, err_cmd, next_err_cmd, next_word_valid;
  logic [15:0] next_words_hold, next_word;
  logic [7:0]  next_err_reg;

  always_comb begin
    next_start_t    = start_t;
    next_words_hold = words_hold;
    next_word_valid = req_s2 ^ req_s3;
    next_word       = WORD_O;
    next_err_cmd    = err_cmd;
    next_err_reg    = ERR_REG_O;
    if (CMD_START_I) begin
      next_start_t    = ~start_t;
      next_words_hold = CMD_WORDS_I;
      next_err_cmd    = 1'b0;
      next_err_reg    = udo_pkg::ERR_RESET;
    end
    // The word register is stable while its toggle is in flight.
    if (req_s2 ^ req_s3) begin
      next_word = hold;
    end
    // Only a miscompare sets the saved error
    if ((done_s2 ^ done_s3) && crc_bad) begin
      next_err_cmd = 1'b1;
    end
    // Report CRC and abort at command end
    if (CMD_END_I) begin
      next_err_reg               = udo_pkg::ERR_RESET;
      next_err_reg[udo_pkg::ERR_ICRC_BIT] = next_err_cmd;
      next_err_reg[udo_pkg::ERR_ABRT_BIT] = next_err_cmd;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      req_s1       <= 1'b0;
      req_s2       <= 1'b0;
      req_s3       <= 1'b0;
      done_s1      <= 1'b0;
      done_s2      <= 1'b0;
      done_s3      <= 1'b0;
      busy_s1      <= 1'b0;
      busy_s2      <= 1'b0;
      start_t      <= 1'b0;
      words_hold   <= udo_pkg::WORDS_RESET;
      WORD_VALID_O <= 1'b0;
      WORD_O       <= 16'h0000;
      err_cmd      <= 1'b0;
      ERR_REG_O    <= udo_pkg::ERR_RESET;
    end else begin
      req_s1       <= req_t;
      req_s2       <= req_s1;
      req_s3       <= req_s2;
      done_s1      <= done_t;
      done_s2      <= done_s1;
      done_s3      <= done_s2;
      busy_s1      <= busy_l;
      busy_s2      <= busy_s1;
      start_t      <= next_start_t;
      words_hold   <= next_words_hold;
      WORD_VALID_O <= next_word_valid;
      WORD_O       <= next_word;
      err_cmd      <= next_err_cmd;
      ERR_REG_O    <= next_err_reg;
    end
  end

  assign BUSY_O = busy_s2;

endmodule : udo_burst

// ===== design/udo_crc16.sv
module udo_crc16 (
  // Running value and word to fold in
  input  wire logic [15:0] crc_i,
  input  wire logic [15:0] word_i,
  // Updated value
  output logic      [15:0] crc_o
);

  logic [15:0] chain [0:16];

  assign chain[0] = crc_i;

  // Bit 0 of the word is shifted in first.
  for (genvar i = 0; i < 16; i++) begin : g_bit
    assign chain[i+1] = {chain[i][14:0], 1'b0} ^ ((chain[i][15] ^ word_i[i]) ? udo_pkg::CRC_POLY : 16'h0000);
  end

  assign crc_o = chain[16];

endmodule : udo_crc16

// ===== design/udo_pkg.sv
package udo_pkg;

  // Link clock period, used to turn the link timings into cycle counts.
  localparam int LINK_PERIOD_NS = 15;

  // Least times on the link, in ns; plain defaults to be set per mode.
  localparam int T_ZIORDY_NS = 20;
  localparam int T_RP_NS     = 160;

  // Least times round up to whole link cycles.
  localparam logic [7:0] ZIORDY_CYC = 8'((T_ZIORDY_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [7:0] RP_CYC     = 8'((T_RP_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);

  // Interface CRC.
  localparam logic [15:0] CRC_SEED = 16'h4ABA;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  // Error register layout and reset values.
  localparam int         ERR_ICRC_BIT = 7;
  localparam int         ERR_ABRT_BIT = 2;
  localparam logic [7:0] ERR_RESET    = 8'h00;
  localparam logic [15:0] WORDS_RESET = 16'h0000;

  // Words the link side can hold while the command side drains them.
  localparam int         SKID_DEPTH = 4;
  localparam logic [2:0] SKID_FULL  = 3'h4;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_REQ     = 3'b001,
    ST_INIT    = 3'b011,
    ST_XFER    = 3'b010,
    ST_PAUSE   = 3'b110,
    ST_WAIT_RP = 3'b111,
    ST_TERM    = 3'b101
  } udo_state_e;

endpackage : udo_pkg

// ===== tb/udo_burst_checker.sv
module udo_burst_checker (
  // Link side of the block
  input wire logic LINK_CLK_I,
  input wire logic RST_I,
  input wire logic DMACK_N_I,
  input wire logic STOP_I,
  input wire logic HSTROBE_I,
  input wire logic DMARQ_O,
  input wire logic DDMARDY_N_O,
  input wire logic DDMARDY_OE_O
);
  logic seen;
  logic next_seen;
  logic hs_q;

  default clocking cb @(posedge LINK_CLK_I);
  endclocking
  default disable iff (RST_I);

  // A strobe fall seen while ready marks the first word, so pauses become legal after it.
  always_comb begin
    next_seen = seen;
    if (DMACK_N_I) begin
      next_seen = 1'h0;
    end else if (hs_q && !HSTROBE_I && DDMARDY_OE_O && !DDMARDY_N_O) begin
      next_seen = 1'h1;
    end
  end

  always_ff @(posedge LINK_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      seen <= 1'h0;
      hs_q <= 1'h1;
    end else begin
      seen <= next_seen;
      hs_q <= HSTROBE_I;
    end
  end

  ack_to_oe_a: assert property ($rose(DDMARDY_OE_O) |-> !DMACK_N_I && !$past(DMACK_N_I, 3) && DMARQ_O)
    else $error("ready driven too early after acknowledge");
  oe_hold_a: assert property (DDMARDY_OE_O && !DMACK_N_I |=> DDMARDY_OE_O)
    else $error("ready released while acknowledged");
  oe_release_a: assert property ($rose(DMACK_N_I) |-> ##[1:5] !DDMARDY_OE_O)
    else $error("ready not released after acknowledge drop");
  first_word_a: assert property (DMARQ_O && DDMARDY_OE_O && !DDMARDY_N_O && !seen |=> DMARQ_O && !DDMARDY_N_O)
    else $error("request or ready dropped before first word");
  stop_end_a: assert property ($rose(STOP_I) && DMARQ_O && seen |-> ##[1:5] !DMARQ_O && DDMARDY_N_O)
    else $error("no response to host stop");
  term_hold_a: assert property (!DMARQ_O && !DMACK_N_I |=> !DMARQ_O && DDMARDY_N_O)
    else $error("request or ready raised during termination");
  rp_wait_a: assert property ($fell(DMARQ_O) && !STOP_I |-> DDMARDY_N_O && $past(DDMARDY_N_O, 11))
    else $error("request dropped too soon after ready");
  ready_ctx_a: assert property ($fell(DDMARDY_N_O) |-> DMARQ_O && DDMARDY_OE_O && !DMACK_N_I)
    else $error("ready asserted outside a burst");
endmodule : udo_burst_checker

bind udo_burst udo_burst_checker i_udo_burst_checker (.LINK_CLK_I, .RST_I, .DMACK_N_I, .STOP_I, .HSTROBE_I,
  .DMARQ_O, .DDMARDY_N_O, .DDMARDY_OE_O);

// ===== tb/udo_burst_test.sv
module udo_burst_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk, link_clk, rst, dmack_n, stop, hstrobe, dmarq, ready_n, ready_oe;
  logic        cmd_start, cmd_end, pause, pause_en, word_valid, busy;
  logic [15:0] dd, cmd_words, word;
  logic [7:0]  err_reg;
  int          failures = 0;
  int          check_count = 0;
  int          got = 0;

  udo_burst i_udo_burst (.REF_CLK_I(ref_clk), .RST_I(rst), .LINK_CLK_I(link_clk), .DMACK_N_I(dmack_n),
    .STOP_I(stop), .HSTROBE_I(hstrobe), .DD_I(dd), .DMARQ_O(dmarq), .DDMARDY_N_O(ready_n),
    .DDMARDY_OE_O(ready_oe), .CMD_START_I(cmd_start), .CMD_WORDS_I(cmd_words), .CMD_END_I(cmd_end),
    .PAUSE_I(pause), .WORD_O(word), .WORD_VALID_O(word_valid), .BUSY_O(busy), .ERR_REG_O(err_reg));

  udo_host i_udo_host (.link_clk_i(link_clk), .dmarq_i(dmarq), .ready_n_i(ready_n), .ready_oe_i(ready_oe),
    .dmack_n_o(dmack_n), .stop_o(stop), .hstrobe_o(hstrobe), .dd_o(dd));

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    link_clk = 1'h0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end

  task automatic check(input logic [15:0] e, input logic [15:0] a);
    check_count++;
    if (a !== e) begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Words must arrive in the order the host strobed them.
  always @(negedge ref_clk) begin
    if (word_valid === 1'h1) begin
      got++;
      check(i_udo_host.sent_q.size() > 0 ? i_udo_host.sent_q.pop_front() : 16'hDEAD, word);
    end
  end

  // Random pause requests reach the device while enabled.
  always @(posedge ref_clk) #1 pause = pause_en & (pause ^ ($urandom_range(15, 0) == 0));

  task automatic run_cmd(input int words, input int b1, input logic bad1);
    logic [7:0] exp_err;
    int         k;
    exp_err = bad1 ? 8'((1 << udo_pkg::ERR_ICRC_BIT) | (1 << udo_pkg::ERR_ABRT_BIT)) : udo_pkg::ERR_RESET;
    i_udo_host.sent_q.delete();
    got = 0;
    cmd_words = 16'(words);
    cmd_start = 1'h1;
    @(posedge ref_clk);
    #1;
    cmd_start = 1'h0;
    i_udo_host.burst(b1, bad1);
    if (b1 < words) begin
      i_udo_host.burst(100, 1'h0);
    end
    k = 0;
    while (busy !== 1'h0 && k < 3000) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k >= 3000 || i_udo_host.timeouts != 0) begin
      failures++;
      report_and_stop();
    end
    cmd_end = 1'h1;
    @(posedge ref_clk);
    #1;
    cmd_end = 1'h0;
    @(posedge ref_clk);
    #1;
    check(16'(exp_err), 16'(err_reg));
    check(16'(words), 16'(got));
  endtask : run_cmd

  initial begin
    int w;
    void'($urandom(32'h8498));
    rst = 1'h1;
    cmd_start = 1'h0;
    cmd_end = 1'h0;
    cmd_words = 16'h0000;
    pause_en = 1'h0;
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'h0;
    check(16'h0008, {11'h000, dmarq, ready_n, ready_oe, word_valid, busy});
    check(16'h0000, {8'h00, err_reg});
    run_cmd(5, 100, 1'h0);
    run_cmd(6, 3, 1'h1);
    pause_en = 1'h1;
    run_cmd(7, 100, 1'h0);
    pause_en = 1'h0;
    repeat (3) begin
      w = $urandom_range(9, 2);
      run_cmd(w, $urandom_range(w - 1, 1), 1'($urandom_range(1, 0)));
    end
    report_and_stop();
  end
endmodule : udo_burst_test

// ===== tb/udo_host.sv
module udo_host (
  // Link clock and device outputs
  input  wire logic        link_clk_i,
  input  wire logic        dmarq_i,
  input  wire logic        ready_n_i,
  input  wire logic        ready_oe_i,
  // Host pins
  output logic             dmack_n_o,
  output logic             stop_o,
  output logic             hstrobe_o,
  output logic      [15:0] dd_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] sent_q[$];
  int          timeouts = 0;

  initial begin
    dmack_n_o = 1'h1;
    stop_o = 1'h0;
    hstrobe_o = 1'h1;
    dd_o = 16'h0000;
  end

  function automatic logic [15:0] fold(input logic [15:0] c, input logic [15:0] d);
    for (int i = 0; i < 16; i++) begin
      c = {c[14:0], 1'h0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction : fold

  task automatic tick(input int n);
    repeat (n) @(negedge link_clk_i);
  endtask : tick

  // Sends at most budget words; the device may end the burst first.
  task automatic burst(input int budget, input logic bad);
    logic [15:0] crc;
    int          n;
    int          k;
    crc = 16'h4ABA;
    n = 0;
    k = 0;
    while (!dmarq_i && k < 3000) begin
      tick(1);
      k++;
    end
    stop_o = 1'h1;
    hstrobe_o = 1'h1;
    tick(2);
    dmack_n_o = 1'h0;
    while (!ready_oe_i && k < 3000) begin
      tick(1);
      k++;
    end
    stop_o = 1'h0;
    while (n < budget && dmarq_i && k < 3000) begin
      if (ready_oe_i && !ready_n_i) begin
        dd_o = 16'($urandom);
        tick(1);
        hstrobe_o = ~hstrobe_o;
        crc = fold(crc, dd_o);
        sent_q.push_back(dd_o);
        n++;
        tick(3);
      end else begin
        tick(1);
        k++;
      end
    end
    tick(2);
    stop_o = 1'h1;
    while ((dmarq_i || !ready_n_i) && k < 3000) begin
      tick(1);
      k++;
    end
    hstrobe_o = 1'h1;
    dd_o = crc ^ {15'h0000, bad};
    tick(3);
    dmack_n_o = 1'h1;
    tick(3);
    stop_o = 1'h0;
    dd_o = ~dd_o;
    if (k >= 3000) begin
      timeouts++;
    end
  endtask : burst
endmodule : udo_host
